/* File: logic/tcci_pkg.sv */
// Purpose: Constants for the transfer completion, chaining and interrupt block.
// Assumes: One 25 MHz clock, asynchronous active-low reset.
// Notes: Register offsets are byte addresses on the plain register port.
`default_nettype none

package tcci_pkg;
  // Bus and vector widths.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CODE_W = 6;
  localparam int NUM_CODES = 64;
  localparam int NUM_REGIONS = 8;
  localparam int NUM_TC = 4;
  // Register byte offsets.
  localparam logic [7:0] OFS_PEND_LO = 8'h00;
  localparam logic [7:0] OFS_PEND_HI = 8'h04;
  localparam logic [7:0] OFS_CLR_LO = 8'h08;
  localparam logic [7:0] OFS_CLR_HI = 8'h0C;
  localparam logic [7:0] OFS_EN_LO = 8'h10;
  localparam logic [7:0] OFS_EN_HI = 8'h14;
  localparam logic [7:0] OFS_REEVALUATE_BIT = 8'h18;
  // Per-region access masks: base plus 8 bytes per region, low word first.
  localparam logic [7:0] OFS_MASK_BASE = 8'h40;
  localparam logic [7:0] OFS_MASK_END = 8'h7C;
  // Reevaluate register field positions: bit 0 global, bits 1..8 regions.
  localparam int REEVALUATE_BIT_GLOBAL_BIT = 0;
  localparam int REEVALUATE_BIT_REGION_LSB = 1;
  // Reset values.
  localparam logic [63:0] PEND_RST = 64'h0;
  localparam logic [63:0] EN_RST = 64'h0;
  localparam logic [63:0] MASK_RST = 64'h0;
  localparam logic [31:0] RD_UNMAPPED = 32'h0;
endpackage : tcci_pkg

`default_nettype wire

/* File: logic/tcci_pulse.sv */
// Purpose: One completion interrupt line, a one-cycle pulse generator.
// Assumes: Active level is already gated by pending and enable, and for region lines also by mask.
// Notes: Pulses on a rising active level or a reevaluate while active.
`timescale 1ns/1ps
`default_nettype none

module tcci_pulse (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic resetn_i,
  // Gated level and reevaluate request.
  input wire logic active_i,
  input wire logic reevaluate_bit_i,
  // Interrupt pulse.
  output logic pulse_o
);
  // Previous active level, for edge detection.
  logic active_q;

  // Remember the gated level.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      active_q <= 1'b0;
    end else begin
      active_q <= active_i;
    end
  end

  // A new pulse needs a none-to-some edge, or a reevaluate while active.
  // A reevaluate in the cycle right after a pulse is absorbed by that pulse,
  // so the line never stays high for two cycles in a row.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pulse_o <= 1'b0;
    end else begin
      pulse_o <= active_i & (~active_q | reevaluate_bit_i) & ~pulse_o;
    end
  end
endmodule // tcci_pulse

`default_nettype wire

/* File: logic/tcci_top.sv */
// Purpose: Completion code capture, channel chaining and completion interrupts.
// Assumes: The request engine reports each transfer request once, with a last flag.
// Notes: All outputs are registered; completion interrupts are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none

module tcci_top (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // Register port.
  input wire logic [tcci_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [tcci_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [tcci_pkg::DATA_W-1:0] reg_rdata_o,
  // Completion report, one per transfer request.
  input wire logic cmpl_valid_i,
  input wire logic [tcci_pkg::CODE_W-1:0] completion_code_i,
  input wire logic cmpl_is_last_i,
  input wire logic final_chain_enable_i,
  input wire logic intermediate_chain_enable_i,
  input wire logic final_irq_enable_i,
  input wire logic intermediate_irq_enable_i,
  // Chain trigger towards the event logic.
  output logic chain_event_o,
  output logic [tcci_pkg::CODE_W-1:0] chain_channel_o,
  // Error and debug sources.
  input wire logic ctrl_err_i,
  input wire logic prot_fault_i,
  input wire logic [tcci_pkg::NUM_TC-1:0] engine_err_i,
  input wire logic debug_evt_i,
  // Completion interrupts.
  output logic global_completion_irq_o,
  output logic [tcci_pkg::NUM_REGIONS-1:0] region_completion_irq_o,
  // Error interrupts and debug trigger.
  output logic controller_error_irq_o,
  output logic protection_fault_irq_o,
  output logic [tcci_pkg::NUM_TC-1:0] transfer_engine_error_irq_o,
  output logic debug_event_trigger_o
);
  import tcci_pkg::*;

  // Pending completion vector, low and high words together.
  logic [NUM_CODES-1:0] completion_pending;
  // Interrupt enable vector.
  logic [NUM_CODES-1:0] completion_irq_enable;
  // Access mask of each region.
  logic [NUM_CODES-1:0] region_mask [NUM_REGIONS];

  // Decoded bit set by the current completion report.
  logic [NUM_CODES-1:0] next_set;
  // Decoded bits cleared by a clear-register write.
  logic [NUM_CODES-1:0] next_clear;
  // Gated enabled-pending vector.
  logic [NUM_CODES-1:0] enabled_pending;
  // Per-region active levels.
  logic [NUM_REGIONS-1:0] region_active;
  // Global active level.
  logic global_active;
  // Reevaluate requests from the evaluate register.
  logic [NUM_REGIONS-1:0] region_reevaluate_bit;
  logic global_reevaluate_bit;
  // Whether this report records an interrupt and whether it chains.
  logic irq_hit;
  logic chain_hit;
  // Register write decodes.
  logic wr_clr_lo;
  logic wr_clr_hi;
  logic wr_reevaluate_bit;
  // Next read data.
  logic [DATA_W-1:0] next_rdata;

  // Decide whether a report records an interrupt.
  // Last request needs the final enable, others the intermediate one.
  always_comb begin
    irq_hit = cmpl_valid_i & (cmpl_is_last_i ? final_irq_enable_i
                                             : intermediate_irq_enable_i);
  end

  // Decide whether a report raises a chain event.
  always_comb begin
    chain_hit = cmpl_valid_i & (cmpl_is_last_i ? final_chain_enable_i
                                               : intermediate_chain_enable_i);
  end

  // Decode the completion code straight onto a pending bit.
  // The code is not tied to the reporting channel in any way.
  always_comb begin
    next_set = '0;
    if (irq_hit) begin
      next_set[completion_code_i] = 1'b1;
    end
  end

  // Write decodes for the registers with side effects.
  always_comb begin
    wr_clr_lo = reg_wr_i & (reg_addr_i == OFS_CLR_LO);
    wr_clr_hi = reg_wr_i & (reg_addr_i == OFS_CLR_HI);
    wr_reevaluate_bit = reg_wr_i & (reg_addr_i == OFS_REEVALUATE_BIT);
  end

  // Bits written with one are cleared; zeros leave pending untouched.
  always_comb begin
    next_clear = '0;
    if (wr_clr_lo) begin
      next_clear[31:0] = reg_wdata_i;
    end
    if (wr_clr_hi) begin
      next_clear[63:32] = reg_wdata_i;
    end
  end

  // Pending vector update; a new completion wins over a clear of the same bit.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      completion_pending <= PEND_RST;
    end else begin
      completion_pending <= (completion_pending & ~next_clear) | next_set;
    end
  end

  // Interrupt enable vector, written as two words.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      completion_irq_enable <= EN_RST;
    end else if (reg_wr_i) begin
      // Low word.
      if (reg_addr_i == OFS_EN_LO) begin
        completion_irq_enable[31:0] <= reg_wdata_i;
      end
      // High word.
      if (reg_addr_i == OFS_EN_HI) begin
        completion_irq_enable[63:32] <= reg_wdata_i;
      end
    end
  end

  // Region access masks; region r sits at base plus 8*r, low word first.
  // These are expected to be set once at start-up and then left alone.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int r = 0; r < NUM_REGIONS; r++) begin
        region_mask[r] <= MASK_RST;
      end
    end else if (reg_wr_i && reg_addr_i >= OFS_MASK_BASE && reg_addr_i <= OFS_MASK_END) begin
      // Word index within the mask block selects region and half.
      if (reg_addr_i[2]) begin
        region_mask[reg_addr_i[5:3]][63:32] <= reg_wdata_i;
      end else begin
        region_mask[reg_addr_i[5:3]][31:0] <= reg_wdata_i;
      end
    end
  end

  // Reevaluate requests come straight from an evaluate-register write.
  // The write is not filtered by any access mask.
  always_comb begin
    global_reevaluate_bit = wr_reevaluate_bit & reg_wdata_i[REEVALUATE_BIT_GLOBAL_BIT];
    region_reevaluate_bit = wr_reevaluate_bit ? reg_wdata_i[REEVALUATE_BIT_REGION_LSB +: NUM_REGIONS]
                          : '0;
  end

  // Gate the pending vector by the enable vector.
  always_comb begin
    enabled_pending = completion_pending & completion_irq_enable;
    global_active = |enabled_pending;
  end

  // Each region adds its own access mask as a second enable.
  always_comb begin
    for (int r = 0; r < NUM_REGIONS; r++) begin
      region_active[r] = |(enabled_pending & region_mask[r]);
    end
  end

  // Global completion interrupt line.
  tcci_pulse u_global_pulse (
    .clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .active_i(global_active),
    .reevaluate_bit_i(global_reevaluate_bit),
    .pulse_o(global_completion_irq_o)
  );

  // One completion interrupt line per region.
  for (genvar g = 0; g < NUM_REGIONS; g++) begin : g_region
    tcci_pulse u_region_pulse (
      .clk_i(sys_clk_i),
      .resetn_i(resetn_i),
      .active_i(region_active[g]),
      .reevaluate_bit_i(region_reevaluate_bit[g]),
      .pulse_o(region_completion_irq_o[g])
    );
  end

  // Chain trigger: a one-cycle event naming the target channel.
  // No parameter set is touched; the target's event logic issues the request.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      chain_event_o <= 1'b0;
    end else begin
      chain_event_o <= chain_hit;
    end
  end

  // Target channel is the completion code of the finishing channel.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      chain_channel_o <= '0;
    end else if (chain_hit) begin
      chain_channel_o <= completion_code_i;
    end
  end

  // Error interrupts and debug trigger are registered copies of their sources.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      controller_error_irq_o <= 1'b0;
      protection_fault_irq_o <= 1'b0;
      transfer_engine_error_irq_o <= '0;
      debug_event_trigger_o <= 1'b0;
    end else begin
      controller_error_irq_o <= ctrl_err_i;
      protection_fault_irq_o <= prot_fault_i;
      transfer_engine_error_irq_o <= engine_err_i;
      debug_event_trigger_o <= debug_evt_i;
    end
  end

  // Read multiplexer; write-only and unmapped offsets read as zero.
  always_comb begin
    next_rdata = RD_UNMAPPED;
    if (reg_addr_i >= OFS_MASK_BASE && reg_addr_i <= OFS_MASK_END) begin
      // Region mask words.
      if (reg_addr_i[2]) begin
        next_rdata = region_mask[reg_addr_i[5:3]][63:32];
      end else begin
        next_rdata = region_mask[reg_addr_i[5:3]][31:0];
      end
    end else begin
      unique case (reg_addr_i)
        // Pending vector, low word.
        OFS_PEND_LO: begin
          next_rdata = completion_pending[31:0];
        end
        // Pending vector, high word.
        OFS_PEND_HI: begin
          next_rdata = completion_pending[63:32];
        end
        // Enable vector, low word.
        OFS_EN_LO: begin
          next_rdata = completion_irq_enable[31:0];
        end
        // Enable vector, high word.
        OFS_EN_HI: begin
          next_rdata = completion_irq_enable[63:32];
        end
        // Anything else, including clear and evaluate registers.
        default: begin
          next_rdata = RD_UNMAPPED;
        end
      endcase
    end
  end

  // Read data stand in the cycle after the read strobe and only there.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      reg_rdata_o <= next_rdata;
    end else begin
      reg_rdata_o <= '0;
    end
  end
endmodule // tcci_top

`default_nettype wire

/* File: tb/tcci_checker.sv */
// Purpose: Port-level timing checks of the completion and chaining block.
// Assumes: Only the ports of tcci_top are visible here.
// Notes: Bound into every tcci_top instance.
`timescale 1ns/1ps
`default_nettype none

module tcci_checker (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // Watched inputs.
  input wire logic reg_wr_i,
  input wire logic cmpl_valid_i,
  input wire logic [tcci_pkg::CODE_W-1:0] completion_code_i,
  input wire logic cmpl_is_last_i,
  input wire logic final_chain_enable_i,
  input wire logic intermediate_chain_enable_i,
  input wire logic ctrl_err_i,
  input wire logic prot_fault_i,
  input wire logic [tcci_pkg::NUM_TC-1:0] engine_err_i,
  // Watched outputs.
  input wire logic chain_event_o,
  input wire logic [tcci_pkg::CODE_W-1:0] chain_channel_o,
  input wire logic controller_error_irq_o,
  input wire logic protection_fault_irq_o,
  input wire logic [tcci_pkg::NUM_TC-1:0] transfer_engine_error_irq_o,
  input wire logic global_completion_irq_o,
  input wire logic [tcci_pkg::NUM_REGIONS-1:0] region_completion_irq_o
);
  import tcci_pkg::*;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  // A report that asks for a chain event; last reports use the final enable.
  logic chain_req;
  assign chain_req = cmpl_valid_i &&
    (cmpl_is_last_i ? final_chain_enable_i : intermediate_chain_enable_i);
  AST_CHAIN: assert property (chain_req |=> chain_event_o &&
    chain_channel_o == $past(completion_code_i)) else $error("chain event or target wrong");
  AST_NO_CHAIN: assert property (!chain_req |=> !chain_event_o)
    else $error("chain event without request");
  AST_CHAIN_HOLD: assert property ($changed(chain_channel_o) |-> chain_event_o)
    else $error("chain target moved alone");
  AST_G_PULSE: assert property (global_completion_irq_o |=> !global_completion_irq_o)
    else $error("global irq longer than one cycle");
  AST_R_PULSE: assert property ((region_completion_irq_o &
    $past(region_completion_irq_o)) == 8'h00) else $error("region irq longer than one cycle");
  // Reports and enable writes pulse two cycles on, an evaluate write one cycle on.
  AST_IRQ_CAUSE: assert property ((global_completion_irq_o || |region_completion_irq_o)
    |-> $past(cmpl_valid_i, 2) || $past(reg_wr_i, 2) || $past(reg_wr_i))
    else $error("irq pulse without cause");
  AST_ERR: assert property (controller_error_irq_o == $past(ctrl_err_i) &&
    protection_fault_irq_o == $past(prot_fault_i)) else $error("error irq copy wrong");
  AST_ENG: assert property (transfer_engine_error_irq_o == $past(engine_err_i))
    else $error("engine irq copy wrong");
endmodule // tcci_checker

bind tcci_top tcci_checker u_chk (.sys_clk_i, .resetn_i, .reg_wr_i, .cmpl_valid_i,
  .completion_code_i, .cmpl_is_last_i, .final_chain_enable_i, .intermediate_chain_enable_i,
  .ctrl_err_i, .prot_fault_i, .engine_err_i, .chain_event_o, .chain_channel_o,
  .controller_error_irq_o, .protection_fault_irq_o, .transfer_engine_error_irq_o,
  .global_completion_irq_o, .region_completion_irq_o);

`default_nettype wire

/* File: tb/tcci_irq_host.sv */
// Purpose: Edge-triggered interrupt controller model that counts pulses.
// Assumes: One clock shared with the block.
// Notes: A level held high is counted once, as a real edge input would.
`timescale 1ns/1ps
`default_nettype none

module tcci_irq_host (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic resetn_i,
  // Interrupt lines.
  input wire logic gint_i,
  input wire logic [7:0] rint_i,
  // Recorded interrupt counts.
  output logic [15:0] g_cnt_o,
  output logic [7:0][15:0] r_cnt_o
);
  logic g_q;
  logic [7:0] r_q;
  // Record rising edges of every line.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      g_q <= 1'b0;
      r_q <= 8'h00;
      g_cnt_o <= 16'h0;
      r_cnt_o <= '0;
    end else begin
      g_q <= gint_i;
      r_q <= rint_i;
      if (gint_i && !g_q) g_cnt_o <= g_cnt_o + 16'h1;
      for (int i = 0; i < 8; i++) if (rint_i[i] && !r_q[i]) r_cnt_o[i] <= r_cnt_o[i] + 16'h1;
    end
  end
endmodule // tcci_irq_host

`default_nettype wire

/* File: tb/tb_tcci_top.sv */
// Purpose: Self-checking bench of the completion, chaining and irq block.
// Assumes: Fixed latencies of the register port and completion report.
// Notes: Completion interrupts are counted by the host model.
`timescale 1ns/1ps
`default_nettype none

module tb_tcci_top;
  import tcci_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, cv = 1'b0, last = 1'b0;
  logic fc = 1'b0, ic = 1'b0, fi = 1'b0, ii = 1'b0, cerr = 1'b0, pf = 1'b0, dbg = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [5:0] code = 6'h00;
  logic [3:0] eerr = 4'h0;
  logic [31:0] rdata;
  logic chev, cerr_o, pf_o, dbg_o, gint;
  logic [5:0] chch;
  logic [3:0] eerr_o;
  logic [7:0] rint;
  logic [15:0] g_cnt;
  logic [7:0][15:0] r_cnt;
  int n_fail = 0, checked = 0, n_chain = 0;
  tcci_top dut (.sys_clk_i(clk), .resetn_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wd),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .cmpl_valid_i(cv),
    .completion_code_i(code), .cmpl_is_last_i(last), .final_chain_enable_i(fc),
    .intermediate_chain_enable_i(ic), .final_irq_enable_i(fi), .intermediate_irq_enable_i(ii),
    .chain_event_o(chev), .chain_channel_o(chch), .ctrl_err_i(cerr), .prot_fault_i(pf),
    .engine_err_i(eerr), .debug_evt_i(dbg), .global_completion_irq_o(gint),
    .region_completion_irq_o(rint), .controller_error_irq_o(cerr_o),
    .protection_fault_irq_o(pf_o), .transfer_engine_error_irq_o(eerr_o),
    .debug_event_trigger_o(dbg_o));
  tcci_irq_host u_host (.clk_i(clk), .resetn_i(rst_n), .gint_i(gint), .rint_i(rint),
    .g_cnt_o(g_cnt), .r_cnt_o(r_cnt));
  // Free-running 25 MHz clock.
  initial begin
    forever #20 clk = ~clk;
  end
  // Count chain events as the event logic would see them.
  always @(posedge clk) if (chev === 1'b1) n_chain <= n_chain + 1;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe.
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // One completion report; en is {final chain, mid chain, final irq, mid irq}.
  task automatic rep(input logic [5:0] c, input logic l, input logic [3:0] en);
    @(posedge clk);
    cv <= 1'b1;
    code <= c;
    last <= l;
    {fc, ic, fi, ii} <= en;
    @(posedge clk);
    cv <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic s_map;
    logic [31:0] d;
    rd_reg(OFS_EN_LO, d);
    chk("enable lo reset", EN_RST[31:0], d);
    rd_reg(8'h7C, d);
    chk("mask r7 hi reset", MASK_RST[63:32], d);
    wr_reg(8'h30, 32'hFFFF_FFFF);
    rd_reg(8'h30, d);
    chk("unmapped", RD_UNMAPPED, d);
    wr_reg(OFS_EN_LO, 32'h4000_0000);
    wr_reg(8'h50, 32'h4000_0000);
    rd_reg(8'h50, d);
    chk("mask r2 lo", 32'h4000_0000, d);
  endtask
  // Requests of one channel with code 30; k picks final, mid or both enables.
  task automatic s_count(input int n, input int k);
    logic [31:0] d;
    int g0, r0, c0, e;
    g0 = g_cnt;
    r0 = r_cnt[2];
    c0 = n_chain;
    e = (k == 0) ? 1 : (k == 1) ? n - 1 : n;
    for (int i = 1; i <= n; i++) begin
      rep(6'h1E, i == n, (k == 0) ? 4'hA : (k == 1) ? 4'h5 : 4'hF);
      rd_reg(OFS_PEND_LO, d);
      if (d[30] === 1'b1) wr_reg(OFS_CLR_LO, 32'h4000_0000);
    end
    chk("chain count", e, n_chain - c0);
    chk("global count", e, g_cnt - g0);
    chk("region2 count", e, r_cnt[2] - r0);
    chk("chain target", 32'h1E, chch);
    rd_reg(OFS_PEND_LO, d);
    chk("pending lo", 32'h0, d);
  endtask
  task automatic s_high;
    logic [31:0] d;
    int g0, r0, c0;
    g0 = g_cnt;
    r0 = r_cnt[5];
    c0 = n_chain;
    wr_reg(OFS_EN_HI, 32'h2);
    wr_reg(8'h6C, 32'h2);
    rep(6'h21, 1'b1, 4'h2);
    rd_reg(OFS_PEND_HI, d);
    chk("pending hi", 32'h2, d);
    rep(6'h28, 1'b0, 4'h1);
    wr_reg(OFS_EN_HI, 32'h102);
    rep(6'h22, 1'b1, 4'h1);
    rd_reg(OFS_PEND_HI, d);
    chk("pending hi two", 32'h102, d);
    chk("global once", g0 + 1, g_cnt);
    chk("region5 once", r0 + 1, r_cnt[5]);
    wr_reg(OFS_CLR_HI, 32'h0);
    wr_reg(OFS_REEVALUATE_BIT, 32'h41);
    repeat (3) @(posedge clk);
    chk("global reevaluate_bit", g0 + 2, g_cnt);
    chk("region5 reevaluate_bit", r0 + 2, r_cnt[5]);
    rd_reg(OFS_PEND_HI, d);
    chk("clear zero", 32'h102, d);
    wr_reg(OFS_CLR_HI, 32'h102);
    rd_reg(OFS_PEND_HI, d);
    chk("cleared hi", 32'h0, d);
    chk("region0 masked", 32'h0, r_cnt[0]);
    for (int r = 1; r < 8; r++) begin
      if (r != 2 && r != 5) chk("region quiet", 32'h0, r_cnt[r]);
    end
    chk("no chain", c0, n_chain);
  endtask
  task automatic s_err;
    @(posedge clk);
    {cerr, pf, eerr, dbg} <= 7'h75;
    repeat (2) @(posedge clk);
    chk("error outs", 7'h75, {cerr_o, pf_o, eerr_o, dbg_o});
    {cerr, pf, eerr, dbg} <= 7'h0A;
    repeat (2) @(posedge clk);
    chk("error outs two", 7'h0A, {cerr_o, pf_o, eerr_o, dbg_o});
  endtask
  task automatic close_out;
    if (n_fail == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    s_map;
    s_count(5, 0);
    s_count(5, 1);
    s_count(5, 2);
    s_count(20, 0);
    s_count(20, 1);
    s_count(20, 2);
    s_high;
    s_err;
    close_out;
  end
  // Guard against a hang.
  initial begin
    #800000;
    n_fail++;
    close_out;
  end
endmodule // tb_tcci_top

`default_nettype wire
